// ==== hw/chdma_transfer_core.sv ====
// dma facing data path and transfer sequencing of the card host controller
`timescale 1ns/10ps
`default_nettype none
module chdma_transfer_core import chdma_pkg::*; #(
  parameter int LEN_W = 12,
  parameter int BLK_W = 16,
  parameter int TOT_W = 28,
  parameter int FIFO_DEPTH = 16,
  parameter int CNT_W = $clog2(FIFO_DEPTH) + 1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  // configuration
  input wire logic dma_handshake_enable,
  input wire logic word_padding_option,
  input wire logic read_overflow_guard,
  input wire logic [CHDMA_CHUNK_W-1:0] burst_chunk_setting,
  input wire logic [CHDMA_LANE_W-1:0] write_byte_offset,
  input wire logic [LEN_W-1:0] block_length,
  input wire logic [BLK_W-1:0] block_count,
  input wire logic write_direction,
  input wire logic data_cmd_start,
  input wire logic stop_cmd_done,
  input wire logic cmd_in_progress,
  input wire logic card_busy,
  // card byte stream
  input wire logic card_rx_valid,
  input wire logic [CHDMA_BYTE_W-1:0] card_rx_byte,
  output logic card_rx_ready,
  output logic card_tx_valid,
  output logic [CHDMA_BYTE_W-1:0] card_tx_byte,
  input wire logic card_tx_ready,
  // dma channel handshake
  output logic dma_req,
  input wire logic dma_wr,
  input wire logic [CHDMA_WORD_W-1:0] dma_wdata,
  input wire logic dma_rd,
  output logic [CHDMA_WORD_W-1:0] dma_rdata,
  // status
  output logic command_ready_flag,
  output logic card_idle_flag,
  output logic fifo_drained_flag,
  output logic transfer_done_flag,
  output logic overrun_flag
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // words per block, rounded up over the leading offset bytes
  function automatic logic [LEN_W:0] block_words(input logic [LEN_W-1:0] len,
                                                 input logic [CHDMA_LANE_W-1:0] off);
    logic [LEN_W+1:0] sum;
    sum = (LEN_W+2)'(len) + (LEN_W+2)'(off) + (LEN_W+2)'(CHDMA_ROUND_UP);
    return (LEN_W+1)'(sum >> CHDMA_WORD_SHIFT);
  endfunction

  function automatic logic [TOT_W-1:0] chunk_words(input logic [CHDMA_CHUNK_W-1:0] sel);
    return TOT_W'(1) << sel;
  endfunction

  chdma_state_e state_q, state_d;
  logic [LEN_W-1:0] byte_cnt_q, byte_cnt_d;
  logic [BLK_W-1:0] blk_cnt_q, blk_cnt_d;
  logic [CHDMA_LANE_W-1:0] lane_q, lane_d;
  logic [CHDMA_WORD_W-1:0] pack_q, pack_d, rdata_q, rdata_d;
  logic [TOT_W-1:0] words_left_q, words_left_d, need;
  logic done_q, done_d, ovr_q, ovr_d, drained_q, cmd_rdy_q, idle_q;
  logic wr_mode_q, wr_mode_d;
  logic fifo_push, fifo_pop, fifo_full, fifo_empty, fifo_clear;
  logic [CHDMA_WORD_W-1:0] fifo_wdata, fifo_rdata;
  logic [CNT_W-1:0] fifo_cnt;
  logic rx_fire, tx_fire, last_byte, word_end, moving;
  logic [CHDMA_LANE_W-1:0] start_lane;

  assign moving = (state_q == CHDMA_MOVE);
  assign rx_fire = card_rx_valid & card_rx_ready;
  assign tx_fire = card_tx_valid & card_tx_ready;
  assign last_byte = (byte_cnt_q == block_length - LEN_W'(1));
  assign word_end = (lane_q == CHDMA_LANE_LAST) | last_byte;
  assign start_lane = wr_mode_q ? write_byte_offset : CHDMA_LANE_FIRST;

  // ----------------------------------------------------------------
  // card side byte path
  // ----------------------------------------------------------------
  // the guard trades card throughput for never losing a received word
  assign card_rx_ready = moving & ~wr_mode_q & ~(read_overflow_guard & fifo_full);
  assign card_tx_valid = moving & wr_mode_q & ~fifo_empty;
  assign card_tx_byte = fifo_rdata[lane_q*CHDMA_BYTE_W +: CHDMA_BYTE_W];

  // fifo fill and drain run side by side; the card waits on an empty or guarded full fifo, the dma on a chunk of words or space
  always_comb begin
    fifo_wdata = pack_q | (CHDMA_WORD_W'(card_rx_byte) << (lane_q * CHDMA_BYTE_W));
    fifo_wdata = wr_mode_q ? dma_wdata : fifo_wdata;
    fifo_push = wr_mode_q ? (dma_wr & ~fifo_full) : (rx_fire & word_end & ~fifo_full);
    fifo_pop = wr_mode_q ? (tx_fire & word_end) : (dma_rd & ~fifo_empty);
    fifo_clear = data_cmd_start & (state_q == CHDMA_IDLE);
  end

  chdma_word_fifo #(
    .WIDTH(CHDMA_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clear(fifo_clear),
    .push(fifo_push),
    .push_data(fifo_wdata),
    .pop(fifo_pop),
    .pop_data(fifo_rdata),
    .full(fifo_full),
    .empty(fifo_empty),
    .count(fifo_cnt)
  );

  // ----------------------------------------------------------------
  // dma request: one chunk, or the short remainder at the end
  // ----------------------------------------------------------------
  always_comb begin
    need = (words_left_q < chunk_words(burst_chunk_setting)) ?
           words_left_q : chunk_words(burst_chunk_setting);
    if (!dma_handshake_enable || words_left_q == '0 || state_q == CHDMA_IDLE) begin
      dma_req = 1'b0;
    end else if (wr_mode_q) begin
      dma_req = (TOT_W'(FIFO_DEPTH) - TOT_W'(fifo_cnt)) >= need;
    end else begin
      dma_req = TOT_W'(fifo_cnt) >= need;
    end
  end

  // ----------------------------------------------------------------
  // sequencing and counters
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    byte_cnt_d = byte_cnt_q;
    blk_cnt_d = blk_cnt_q;
    lane_d = lane_q;
    pack_d = pack_q;
    words_left_d = words_left_q;
    wr_mode_d = wr_mode_q;
    done_d = done_q;
    ovr_d = ovr_q;
    rdata_d = rdata_q;
    if (!wr_mode_q && dma_rd && !fifo_empty) begin
      rdata_d = fifo_rdata;
    end
    if ((wr_mode_q ? fifo_push : fifo_pop) && words_left_q != '0) begin
      words_left_d = words_left_q - TOT_W'(1);
    end
    if (rx_fire) begin
      pack_d[lane_q*CHDMA_BYTE_W +: CHDMA_BYTE_W] = card_rx_byte;
      if (word_end && fifo_full) begin
        ovr_d = 1'b1; // word lost, only possible with the guard off
      end
    end
    if (rx_fire | tx_fire) begin
      lane_d = lane_q + CHDMA_LANE_W'(1);
      byte_cnt_d = byte_cnt_q + LEN_W'(1);
      if (last_byte) begin
        byte_cnt_d = '0;
        lane_d = start_lane;
        blk_cnt_d = blk_cnt_q + BLK_W'(1);
        if (blk_cnt_q == block_count - BLK_W'(1)) begin
          state_d = CHDMA_DRAIN;
        end
      end
    end
    // a ragged tail leaves upper lanes zero, giving the padded word
    if (rx_fire && word_end) begin
      pack_d = '0;
    end
    unique case (state_q)
      CHDMA_IDLE: begin
        if (data_cmd_start) begin
          wr_mode_d = write_direction;
          state_d = CHDMA_MOVE;
          byte_cnt_d = '0;
          blk_cnt_d = '0;
          pack_d = '0;
          done_d = 1'b0;
          ovr_d = 1'b0;
          lane_d = write_direction ? write_byte_offset : CHDMA_LANE_FIRST;
          words_left_d = TOT_W'(block_count) * TOT_W'(block_words(block_length,
                         write_direction ? write_byte_offset : CHDMA_LANE_FIRST));
        end
      end
      CHDMA_MOVE: begin
      end
      CHDMA_DRAIN: begin
        if (wr_mode_q || (fifo_empty && words_left_q == '0)) begin
          state_d = (block_count > BLK_W'(1)) ? CHDMA_STOP : CHDMA_DONE;
        end
      end
      CHDMA_STOP: begin
        if (stop_cmd_done) begin
          state_d = CHDMA_DONE;
        end
      end
      CHDMA_DONE: begin
        done_d = 1'b1;
        state_d = CHDMA_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= CHDMA_IDLE;
      byte_cnt_q <= '0;
      blk_cnt_q <= '0;
      lane_q <= CHDMA_LANE_FIRST;
      pack_q <= '0;
      words_left_q <= '0;
      wr_mode_q <= 1'b0;
      done_q <= 1'b0;
      ovr_q <= 1'b0;
      rdata_q <= '0;
      drained_q <= 1'b1;
      cmd_rdy_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      state_q <= state_d;
      byte_cnt_q <= byte_cnt_d;
      blk_cnt_q <= blk_cnt_d;
      lane_q <= lane_d;
      pack_q <= pack_d;
      words_left_q <= words_left_d;
      wr_mode_q <= wr_mode_d;
      done_q <= done_d;
      ovr_q <= ovr_d;
      rdata_q <= rdata_d;
      drained_q <= fifo_empty;
      cmd_rdy_q <= ~cmd_in_progress;
      idle_q <= ~card_busy;
    end
  end

  // read data and status flags for software polling
  assign dma_rdata = rdata_q;
  assign fifo_drained_flag = drained_q;
  assign transfer_done_flag = done_q;
  assign overrun_flag = ovr_q;
  assign command_ready_flag = cmd_rdy_q;
  assign card_idle_flag = idle_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_req_needs_en: assert property (@(posedge sys_clk) disable iff (!rst_b)
    dma_req |-> dma_handshake_enable) else $error("request without dma enable");
  a_guard_no_ovr: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (read_overflow_guard && fifo_full) |-> !card_rx_ready) else $error("rx taken while full");
  a_pad_tail_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (fifo_push && !wr_mode_q && last_byte && word_padding_option) |->
    (fifo_wdata >> ((int'(lane_q) + 1) * CHDMA_BYTE_W)) == '0) else $error("padded tail not zero");
  a_drained_track: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fifo_empty |=> fifo_drained_flag) else $error("drained flag missed empty fifo");
  a_done_stop: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == CHDMA_STOP && !stop_cmd_done) |=> !transfer_done_flag)
    else $error("done before stop command");
  a_done_rise: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(transfer_done_flag) |-> $past(state_q) == CHDMA_DONE && state_q == CHDMA_IDLE)
    else $error("done rose outside done state");
  a_chunk_req: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (dma_req && !wr_mode_q) |->
    (TOT_W'(fifo_cnt) >= chunk_words(burst_chunk_setting) || TOT_W'(fifo_cnt) >= words_left_q))
    else $error("read request without a chunk");
  a_offset_lane: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == CHDMA_IDLE && data_cmd_start && write_direction)
    |=> lane_q == $past(write_byte_offset)) else $error("offset not applied");
  a_words_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == CHDMA_IDLE && data_cmd_start && block_count == BLK_W'(1) && !write_direction)
    |=> words_left_q == TOT_W'(($past(block_length) + CHDMA_ROUND_UP) >> CHDMA_WORD_SHIFT))
    else $error("word count not rounded up");
endmodule
`default_nettype wire

// ==== hw/chdma_pkg.sv ====
// shared constants and types for the card host dma transfer block
package chdma_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CHDMA_WORD_W = 32;
  localparam int CHDMA_BYTE_W = 8;
  localparam int CHDMA_LANE_W = 2;
  localparam int CHDMA_CHUNK_W = 3;
  localparam logic [CHDMA_LANE_W-1:0] CHDMA_LANE_LAST = 2'h3;
  localparam logic [CHDMA_LANE_W-1:0] CHDMA_LANE_FIRST = 2'h0;
  localparam int CHDMA_WORD_SHIFT = 2;
  localparam int CHDMA_ROUND_UP = 3;
  // ----------------------------------------------------------------
  // transfer sequencing states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CHDMA_IDLE,
    CHDMA_MOVE,
    CHDMA_DRAIN,
    CHDMA_STOP,
    CHDMA_DONE
  } chdma_state_e;
endpackage

// ==== hw/chdma_word_fifo.sv ====
// word fifo between the card byte path and the dma word path
`timescale 1ns/10ps
`default_nettype none
module chdma_word_fifo import chdma_pkg::*; #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  output logic full,
  output logic empty,
  output logic [AW:0] count
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  // ----------------------------------------------------------------
  // pointers and count
  // ----------------------------------------------------------------
  // a push into a full fifo or a pop from an empty one is ignored
  always_comb begin
    do_push = push & ~full;
    do_pop = pop & ~empty;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    cnt_d = cnt_q;
    if (clear) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      cnt_d = '0;
    end else begin
      if (do_push) begin
        wr_ptr_d = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (do_pop) begin
        rd_ptr_d = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
      end
      if (do_push & ~do_pop) begin
        cnt_d = cnt_q + (AW+1)'(1);
      end else if (do_pop & ~do_push) begin
        cnt_d = cnt_q - (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset; only words below the count are ever read
  always_ff @(posedge sys_clk) begin
    if (do_push && !clear) begin
      mem_q[wr_ptr_q] <= push_data;
    end
  end

  assign pop_data = mem_q[rd_ptr_q];
  assign full = (cnt_q == (AW+1)'(DEPTH));
  assign empty = (cnt_q == '0);
  assign count = cnt_q;
endmodule
`default_nettype wire

// ==== verif/chdma_dma_model.sv ====
// dma channel model that answers the block's request handshake
`timescale 1ns/10ps
`default_nettype none
module chdma_dma_model import chdma_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic dma_req,
  input wire logic [CHDMA_CHUNK_W-1:0] chunk,
  input wire logic slow,
  output logic dma_wr,
  output logic [CHDMA_WORD_W-1:0] dma_wdata,
  output logic dma_rd,
  input wire logic [CHDMA_WORD_W-1:0] dma_rdata
);
  int left = 0;
  int burst = 0;
  int gap = 0;
  bit to_card = 0;
  bit go = 0;
  logic [CHDMA_WORD_W-1:0] tx_q[$];
  logic [CHDMA_WORD_W-1:0] rx_q[$];
  initial begin
    dma_wr = 1'h0;
    dma_rd = 1'h0;
    dma_wdata = 32'hA5C30F96;
  end
  // the channel is armed only once count and direction are known
  // arming drops any stale burst or gap, so a reused channel starts clean
  task automatic arm(input int n, input bit w);
    burst = 0;
    gap = 0;
    left = n;
    to_card = w;
  endtask
  // one word per cycle in bursts; an idle data bus shows garbage, not the last word
  always @(negedge sys_clk) begin
    if (dma_rd) rx_q.push_back(dma_rdata);
    go = 0;
    if (!rst_b) begin
      burst = 0;
      gap = 0;
    end else if (gap > 0) gap--;
    else begin
      if (burst == 0 && dma_req && left > 0) begin
        burst = left < (1 << chunk) ? left : 1 << chunk;
      end
      if (burst > 0) begin
        burst--;
        left--;
        go = 1;
        if (burst == 0 && slow) gap = 3;
      end
    end
    dma_rd <= go && !to_card;
    dma_wr <= go && to_card;
    dma_wdata <= (go && to_card) ? tx_q.pop_front() : ~dma_wdata;
  end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the card host dma transfer core
`timescale 1ns/10ps
`default_nettype none
module tb_top import chdma_pkg::*;;
  logic sys_clk = 0, rst_b = 0, dma_handshake_enable = 0, word_padding_option = 1;
  logic read_overflow_guard = 1, write_direction = 0, data_cmd_start = 0, stop_cmd_done = 0;
  logic cmd_in_progress = 0, card_busy = 0, card_rx_valid = 0, card_tx_ready = 0;
  logic slow = 0, tx_stall = 0;
  logic [CHDMA_CHUNK_W-1:0] burst_chunk_setting = '0;
  logic [CHDMA_LANE_W-1:0] write_byte_offset = '0;
  logic [11:0] block_length = '0;
  logic [15:0] block_count = '0;
  logic [CHDMA_BYTE_W-1:0] card_rx_byte = '0, card_tx_byte;
  logic card_rx_ready, card_tx_valid, dma_req, dma_wr, dma_rd, overrun_flag;
  logic command_ready_flag, card_idle_flag, fifo_drained_flag, transfer_done_flag;
  logic [CHDMA_WORD_W-1:0] dma_wdata, dma_rdata;
  logic [7:0] tx_got[$];
  int failures = 0, checked = 0;
  chdma_transfer_core chdma_transfer_core_i (.sys_clk, .rst_b, .dma_handshake_enable,
    .word_padding_option, .read_overflow_guard, .burst_chunk_setting, .write_byte_offset,
    .block_length, .block_count, .write_direction, .data_cmd_start, .stop_cmd_done,
    .cmd_in_progress, .card_busy, .card_rx_valid, .card_rx_byte, .card_rx_ready,
    .card_tx_valid, .card_tx_byte, .card_tx_ready, .dma_req, .dma_wr, .dma_wdata, .dma_rd,
    .dma_rdata, .command_ready_flag, .card_idle_flag, .fifo_drained_flag,
    .transfer_done_flag, .overrun_flag);
  chdma_dma_model chdma_dma_model_i (.sys_clk, .rst_b, .dma_req, .chunk(burst_chunk_setting),
    .slow, .dma_wr, .dma_wdata, .dma_rd, .dma_rdata);
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // hang guard at 20000 cycles, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    failures++;
    $display("[FAIL] %0t watchdog", $time);
    end_of_test;
  end
  // card sink; stalling every other cycle proves the lane walk waits for acceptance
  always @(negedge sys_clk) begin
    card_tx_ready = ~card_tx_ready | ~tx_stall;
    #1;
    if (card_tx_valid === 1'b1 && card_tx_ready) tx_got.push_back(card_tx_byte);
  end
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task start(input logic w, input int len, input int cnt, input int off, input int ck);
    @(negedge sys_clk);
    chk({command_ready_flag, card_idle_flag}, 2'h3, "not idle");
    write_direction = w;
    block_length = 12'(len);
    block_count = 16'(cnt);
    write_byte_offset = 2'(off);
    burst_chunk_setting = 3'(ck);
    data_cmd_start = 1;
    tick(1);
    data_cmd_start = 0;
    tick(1);
    chk(transfer_done_flag, 0, "done kept");
  endtask
  // card bytes held until the block takes them
  task send(input int n, input logic [7:0] base);
    int i;
    int t;
    for (i = 0; i < n; i++) begin
      @(negedge sys_clk);
      card_rx_valid = 1;
      card_rx_byte = base + 8'(i);
      t = 0;
      #2;
      while (card_rx_ready !== 1'b1 && t < 200) begin
        @(negedge sys_clk);
        #2;
        t++;
      end
      chk(t < 200, 1, "rx timeout");
    end
    @(negedge sys_clk);
    card_rx_valid = 0;
    card_rx_byte = ~card_rx_byte;
  endtask
  task finish(input bit multi);
    int t;
    t = 0;
    while (!(chdma_dma_model_i.left == 0 && fifo_drained_flag === 1'b1) && t < 4000) begin
      tick(1);
      t++;
    end
    chk(t < 4000, 1, "drain timeout");
    if (multi) begin
      tick(12);
      chk(transfer_done_flag, 0, "done before stop");
      chk(fifo_drained_flag, 1, "fifo not drained");
      stop_cmd_done = 1;
      tick(1);
      stop_cmd_done = 0;
    end
    t = 0;
    while (transfer_done_flag !== 1'b1 && t < 100) begin
      tick(1);
      t++;
    end
    chk(transfer_done_flag, 1, "no done");
    dma_handshake_enable = 0;
  endtask
  // words as the dma should see them: little endian, ragged tail zero filled
  task rx_chk(input int nb, input int len, input logic [7:0] base);
    int b;
    int w;
    int l;
    int p;
    logic [31:0] e;
    chk(chdma_dma_model_i.rx_q.size(), nb * ((len + 3) / 4), "word count");
    for (b = 0; b < nb; b++) begin
      for (w = 0; w < (len + 3) / 4; w++) begin
        for (l = 0; l < 4; l++) begin
          p = w * 4 + l;
          e[8*l+:8] = p < len ? base + 8'(b * len + p) : 8'h00;
        end
        chk(chdma_dma_model_i.rx_q.pop_front(), e, "dma word");
      end
    end
  endtask
  initial begin
    int b;
    int q;
    tick(5);
    chk(fifo_drained_flag, 1, "reset drained");
    chk(dma_req, 0, "reset req");
    rst_b = 1;
    cmd_in_progress = 1;
    card_busy = 1;
    tick(2);
    chk({command_ready_flag, card_idle_flag}, 2'h0, "busy flags");
    cmd_in_progress = 0;
    card_busy = 0;
    tick(2);
    // single padded read of six bytes
    dma_handshake_enable = 1;
    chdma_dma_model_i.arm(2, 0);
    start(0, 6, 1, 0, 0);
    send(6, 8'h01);
    finish(0);
    rx_chk(1, 6, 8'h01);
    // two-block read, padding off, two-word bursts, slow channel alongside card traffic
    slow = 1;
    word_padding_option = 0;
    dma_handshake_enable = 1;
    chdma_dma_model_i.arm(4, 0);
    start(0, 8, 2, 0, 1);
    send(16, 8'h10);
    finish(1);
    rx_chk(2, 8, 8'h10);
    slow = 0;
    word_padding_option = 1;
    // two-block write, five bytes each, source offset one
    for (q = 0; q < 4; q++) begin
      chdma_dma_model_i.tx_q.push_back({4'(q), 4'h3, 4'(q), 4'h2, 4'(q), 4'h1, 4'(q), 4'h0});
    end
    tx_stall = 1;
    dma_handshake_enable = 1;
    chdma_dma_model_i.arm(4, 1);
    start(1, 5, 2, 1, 1);
    finish(1);
    chk(tx_got.size(), 10, "byte count");
    for (b = 0; b < 10; b++) begin
      chk(tx_got.pop_front(), {4'(b / 5 * 2 + (1 + b % 5) / 4), 4'((1 + b % 5) % 4)},
          "card byte");
    end
    tx_stall = 0;
    // requests held off while disabled, guard stalls the card when full
    chdma_dma_model_i.arm(17, 0);
    start(0, 68, 1, 0, 0);
    send(64, 8'h00);
    tick(4);
    chk(dma_req, 0, "req while disabled");
    chk(fifo_drained_flag, 0, "drained with data");
    card_rx_valid = 1;
    card_rx_byte = 8'h40;
    #2;
    chk(card_rx_ready, 0, "ready while full");
    dma_handshake_enable = 1;
    send(4, 8'h40);
    finish(0);
    rx_chk(1, 68, 8'h00);
    chk(overrun_flag, 0, "overrun");
    end_of_test;
  end
endmodule
`default_nettype wire
